// file: drbk_pkg.sv
package drbk_pkg;
  // mode-register addresses
  localparam logic [7:0] MA_BASIC_CONFIG_THREE = 8'h07;
  localparam logic [7:0] MA_BASIC_CONFIG_FOUR = 8'h08;
  localparam logic [7:0] MA_VENDOR_TEST_REG = 8'h09;
  localparam logic [7:0] MA_IO_CALIBRATION_REG = 8'h0A;
  localparam logic [7:0] MA_TERMINATION_FEATURE_REG = 8'h0B;
  localparam logic [7:0] MA_CA_REFERENCE_REG = 8'h0C;
  localparam logic [7:0] MA_TRAINING_AND_SETPOINT_REG = 8'h0D;
  // field positions
  localparam int SE_SUPPORT_BIT = 0;
  localparam int REVISION_LSB = 1;
  localparam int TYPE_LSB = 0;
  localparam int DENSITY_LSB = 2;
  localparam int WIDTH_LSB = 6;
  localparam int CAL_DEFAULT_RESET_BIT = 0;
  localparam int REF_LEVEL_LSB = 0;
  localparam int REF_RANGE_BIT = 6;
  localparam int SETPOINT_WRITE_BIT = 6;
  localparam int SETPOINT_OPERATE_BIT = 7;
  // encodings and reset values
  localparam logic [1:0] TYPE_SIXTEEN_PREFETCH = 2'h0;
  localparam logic [1:0] WIDTH_X16_PER_CHANNEL = 2'h0;
  localparam logic [5:0] REF_LEVEL_CODE_MAX = 6'h32;
  localparam logic [6:0] CA_REFERENCE_RESET = 7'h4D;
  localparam logic [7:0] TERMINATION_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // cycles after reset release before the calibration strap is caught
  localparam logic [2:0] STRAP_WAIT_CYCLES = 3'h5;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic mrw;
    logic mrr;
    logic cal;
    logic [7:0] ma;
    logic [7:0] op;
  } drbk_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DRIVE = 3'b100
  } drbk_state_e;

  function automatic logic drbk_hit(input logic [7:0] ma, input logic [7:0] addr);
    drbk_hit = (ma == addr);
  endfunction
endpackage

// file: drbk_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser; the output moves only when stages two and three agree
module drbk_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        q <= s3_r;
      end
    end
  end
endmodule

// file: drbk_setpoint.sv
`timescale 1ns/1ns
// two physical copies of one mode-register field
module drbk_setpoint #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_sel,
  input wire logic op_sel,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rd_data,
  output logic [W-1:0] act_data
);
  logic [W-1:0] copy_r [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_copy
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          copy_r[g] <= RESET_VAL;
        end
        // RL16: selected copy written
        else if (wr_en && (wr_sel == 1'(g)))
        begin
          copy_r[g] <= wdata;
        end
      end
    end
  endgenerate

  // RL16: readback from write copy
  assign rd_data = copy_r[wr_sel];
  // RL17: operate from active copy
  assign act_data = copy_r[op_sel];
endmodule

// file: drbk_mode_regs.sv
`timescale 1ns/1ns
// What the document requires
// RL1: eight-bit address selects each mode register
// RL2: bit 0 reports single-ended support
// RL3: controller enables single-ended only if supported
// RL4: bits 7..1 report secondary revision code
// RL5: type field reports sixteen-prefetch code
// RL6: density field read-only, codes 0..6
// RL7: width field reports sixteen bits per channel
// RL8: controller writes only zero to test register
// RL9: calibration bit 0 write-only default reset
// RL10: grounded calibration pin ignores calibration commands
// RL11: reference level code six bits, max 110010
// RL12: bit 6 selects reference range, default one
// RL13: reference setting held until overwritten or reset
// RL14: read drives eight bits, reserved bits zero
// RL15: level write goes to write-selected copy
// RL16: access only the write-selected copy
// RL17: operate only from operation-selected copy
// RL18: writes to read-only fields are ignored
module drbk_mode_regs #(
  // value is arbitrary
  parameter logic [6:0] REVISION_CODE = 7'h2A,
  parameter logic SE_SUPPORTED = 1'b0,
  parameter logic [3:0] DENSITY_CODE = 4'h4
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CK,
  input wire logic CMD_MRW,
  input wire logic CMD_MRR,
  input wire logic CMD_CAL,
  input wire logic [7:0] CMD_MA,
  input wire logic [7:0] CMD_OP,
  input wire logic CAL_PIN_TO_RESISTOR,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE,
  output logic [5:0] CA_REF_LEVEL,
  output logic CA_REF_RANGE,
  output logic [7:0] TERM_FEATURE,
  output logic SETPOINT_WRITE,
  output logic SETPOINT_OPERATE,
  output logic CAL_USE_DEFAULT,
  output logic CAL_RUN,
  output logic CAL_DEFAULT_RESET
);
  drbk_pkg::drbk_cmd_s cmd_raw;
  drbk_pkg::drbk_cmd_s cmd_sync;
  drbk_pkg::drbk_cmd_s cmd_r;
  drbk_pkg::drbk_cmd_s cmd_nxt;
  drbk_pkg::drbk_state_e state_r;
  drbk_pkg::drbk_state_e state_nxt;
  logic ck_sync;
  logic ck_d_r;
  logic ck_rise;
  logic strap_sync;
  logic [2:0] strap_cnt_r;
  logic strap_done_r;
  logic strap_resistor_r;
  logic sp_write_r;
  logic sp_write_nxt;
  logic sp_operate_r;
  logic sp_operate_nxt;
  logic exec;
  logic wr_exec;
  logic rd_exec;
  logic wr_ca;
  logic wr_term;
  logic wr_sp;
  logic wr_cal;
  logic level_ok;
  logic [6:0] ca_rd;
  logic [6:0] ca_act;
  logic [7:0] term_rd;
  logic [7:0] term_act;
  logic [7:0] basic_config_three;
  logic [7:0] basic_config_four;
  logic [7:0] setpoint_rd;
  logic [7:0] rd_data;
  logic [7:0] dq_out_nxt;
  logic dq_oe_nxt;
  logic cal_run_nxt;
  logic cal_reset_nxt;

  assign cmd_raw = '{mrw: CMD_MRW, mrr: CMD_MRR, cal: CMD_CAL, ma: CMD_MA, op: CMD_OP};

  // command pins and the command clock settle through the same depth, so the
  // command seen at a detected clock rise is the one set up for that edge
  drbk_sync #(.W($bits(drbk_pkg::drbk_cmd_s))) u_cmd_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(cmd_raw),
    .q(cmd_sync)
  );

  drbk_sync #(.W(1)) u_ck_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(CK),
    .q(ck_sync)
  );

  drbk_sync #(.W(1)) u_strap_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(CAL_PIN_TO_RESISTOR),
    .q(strap_sync)
  );

  assign ck_rise = ck_sync && !ck_d_r;

  // command sequencer
  always_comb
  begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    case (state_r)
      drbk_pkg::ST_IDLE:
      begin
        if (ck_rise)
        begin
          cmd_nxt = cmd_sync;
          state_nxt = drbk_pkg::ST_EXEC;
        end
      end
      drbk_pkg::ST_EXEC:
      begin
        state_nxt = cmd_r.mrr ? drbk_pkg::ST_DRIVE : drbk_pkg::ST_IDLE;
      end
      drbk_pkg::ST_DRIVE:
      begin
        // read data stands until the next command-clock rise
        if (ck_rise)
        begin
          cmd_nxt = cmd_sync;
          state_nxt = drbk_pkg::ST_EXEC;
        end
      end
      default:
      begin
        state_nxt = drbk_pkg::ST_IDLE;
      end
    endcase
  end

  // RL1: address decode
  assign exec = (state_r == drbk_pkg::ST_EXEC);
  assign wr_exec = exec && cmd_r.mrw;
  assign rd_exec = exec && cmd_r.mrr;
  // RL11: reserved codes not stored
  assign level_ok = (cmd_r.op[5:0] <= drbk_pkg::REF_LEVEL_CODE_MAX);
  // RL12: range written with level
  assign wr_ca = wr_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_CA_REFERENCE_REG) && level_ok;
  assign wr_term = wr_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_TERMINATION_FEATURE_REG);
  assign wr_sp = wr_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_TRAINING_AND_SETPOINT_REG);
  assign wr_cal = wr_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_IO_CALIBRATION_REG);

  // only the two selector bits of the set-point register live here
  assign sp_write_nxt = wr_sp ? cmd_r.op[drbk_pkg::SETPOINT_WRITE_BIT] : sp_write_r;
  assign sp_operate_nxt = wr_sp ? cmd_r.op[drbk_pkg::SETPOINT_OPERATE_BIT] : sp_operate_r;

  // RL15: level to write-selected copy
  // RL13: held until write or reset
  drbk_setpoint #(.W(7), .RESET_VAL(drbk_pkg::CA_REFERENCE_RESET)) u_ca_ref (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_en(wr_ca),
    .wr_sel(sp_write_r),
    .op_sel(sp_operate_r),
    .wdata(cmd_r.op[6:0]),
    .rd_data(ca_rd),
    .act_data(ca_act)
  );

  drbk_setpoint #(.W(8), .RESET_VAL(drbk_pkg::TERMINATION_RESET)) u_term (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_en(wr_term),
    .wr_sel(sp_write_r),
    .op_sel(sp_operate_r),
    .wdata(cmd_r.op),
    .rd_data(term_rd),
    .act_data(term_act)
  );

  // RL18: no write path here
  // RL2: single-ended support bit
  // RL4: revision code field
  assign basic_config_three = {REVISION_CODE, SE_SUPPORTED};
  // RL5: type field
  // RL6: density field
  // RL7: width field
  assign basic_config_four = {drbk_pkg::WIDTH_X16_PER_CHANNEL, DENSITY_CODE, drbk_pkg::TYPE_SIXTEEN_PREFETCH};
  assign setpoint_rd = {sp_operate_r, sp_write_r, 6'h00};

  // RL14: read mux, reserved bits zero
  assign rd_data =
    drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_BASIC_CONFIG_THREE) ? basic_config_three :
    drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_BASIC_CONFIG_FOUR) ? basic_config_four :
    drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_TERMINATION_FEATURE_REG) ? term_rd :
    drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_CA_REFERENCE_REG) ? {1'b0, ca_rd} :
    drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_TRAINING_AND_SETPOINT_REG) ? setpoint_rd :
    drbk_pkg::READ_ZERO;

  assign dq_out_nxt = rd_exec ? rd_data : (ck_rise ? drbk_pkg::READ_ZERO : DQ_OUT);
  assign dq_oe_nxt = rd_exec ? 1'b1 : (ck_rise ? 1'b0 : DQ_OE);

  // RL10: grounded pin ignores calibration
  assign cal_run_nxt = exec && cmd_r.cal && strap_resistor_r;
  // RL9: default calibration reset pulse
  assign cal_reset_nxt = wr_cal && cmd_r.op[drbk_pkg::CAL_DEFAULT_RESET_BIT] && strap_resistor_r;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= drbk_pkg::ST_IDLE;
      cmd_r <= '0;
      ck_d_r <= 1'b0;
      sp_write_r <= 1'b0;
      sp_operate_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      ck_d_r <= ck_sync;
      sp_write_r <= sp_write_nxt;
      sp_operate_r <= sp_operate_nxt;
    end
  end

  // the strap is caught once the synchroniser has settled; it must not move later
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strap_cnt_r <= 3'h0;
      strap_done_r <= 1'b0;
      strap_resistor_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == drbk_pkg::STRAP_WAIT_CYCLES)
      begin
        strap_done_r <= 1'b1;
        strap_resistor_r <= strap_sync;
      end
    end
  end

  // RL17: set-point outputs follow active copy
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DQ_OUT <= drbk_pkg::READ_ZERO;
      DQ_OE <= 1'b0;
      CA_REF_LEVEL <= drbk_pkg::CA_REFERENCE_RESET[5:0];
      CA_REF_RANGE <= drbk_pkg::CA_REFERENCE_RESET[drbk_pkg::REF_RANGE_BIT];
      TERM_FEATURE <= drbk_pkg::TERMINATION_RESET;
      SETPOINT_WRITE <= 1'b0;
      SETPOINT_OPERATE <= 1'b0;
      CAL_USE_DEFAULT <= 1'b1;
      CAL_RUN <= 1'b0;
      CAL_DEFAULT_RESET <= 1'b0;
    end
    else
    begin
      DQ_OUT <= dq_out_nxt;
      DQ_OE <= dq_oe_nxt;
      CA_REF_LEVEL <= ca_act[5:0];
      CA_REF_RANGE <= ca_act[drbk_pkg::REF_RANGE_BIT];
      TERM_FEATURE <= term_act;
      SETPOINT_WRITE <= sp_write_r;
      SETPOINT_OPERATE <= sp_operate_r;
      CAL_USE_DEFAULT <= !strap_resistor_r;
      CAL_RUN <= cal_run_nxt;
      CAL_DEFAULT_RESET <= cal_reset_nxt;
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence seq_read_taken;
    rd_exec;
  endsequence

  sequence seq_read_drive;
    DQ_OE && (DQ_OUT == $past(rd_data));
  endsequence

  read_drive_a: assert property (seq_read_taken |=> seq_read_drive) // RL14
    else $error("read data not driven after read");

  read_rfu_zero_a: assert property (rd_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_CA_REFERENCE_REG) // RL14
    |=> !DQ_OUT[7])
    else $error("reserved read bit not zero");

  ident_read_a: assert property (rd_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_BASIC_CONFIG_THREE) // RL4
    |=> DQ_OUT == {REVISION_CODE, SE_SUPPORTED})
    else $error("revision register read wrong");

  config_read_a: assert property (rd_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_BASIC_CONFIG_FOUR) // RL6
    |=> DQ_OUT == {2'h0, DENSITY_CODE, 2'h0})
    else $error("configuration register read wrong");

  level_write_a: assert property (wr_ca && !wr_sp |=> ca_rd == $past(cmd_r.op[6:0])) // RL15
    else $error("written level not read back");

  level_reserved_a: assert property (wr_exec && drbk_pkg::drbk_hit(cmd_r.ma, drbk_pkg::MA_CA_REFERENCE_REG) // RL11
    && (cmd_r.op[5:0] > drbk_pkg::REF_LEVEL_CODE_MAX) && !wr_sp |=> $stable(ca_rd))
    else $error("reserved level code stored");

  level_hold_a: assert property (!wr_ca && !wr_sp |=> $stable(ca_rd)) // RL13
    else $error("level changed without write");

  inactive_copy_a: assert property (wr_ca && (sp_write_r != sp_operate_r) |=> ##1 $stable(CA_REF_LEVEL)) // RL17
    else $error("inactive copy write moved level");

  // checked against the copy picked by the selector, not the mux output itself
  active_follow_a: assert property (##1 CA_REF_LEVEL == // RL17
    $past(sp_operate_r ? u_ca_ref.copy_r[1][5:0] : u_ca_ref.copy_r[0][5:0]))
    else $error("level output not from active copy");

  cal_ignore_a: assert property (!strap_resistor_r |=> !CAL_RUN && !CAL_DEFAULT_RESET) // RL10
    else $error("calibration honoured with grounded pin");

  sequence seq_cal_pulse;
    CAL_DEFAULT_RESET ##1 !CAL_DEFAULT_RESET;
  endsequence

  cal_reset_a: assert property (wr_cal && cmd_r.op[0] && strap_resistor_r |=> seq_cal_pulse) // RL9
    else $error("default calibration reset not pulsed");

  dq_release_a: assert property (ck_rise |=> !DQ_OE && (DQ_OUT == drbk_pkg::READ_ZERO)) // RL14
    else $error("read data not released on next command");

  selector_write_a: assert property (wr_sp |=> (sp_write_r == $past(cmd_r.op[drbk_pkg::SETPOINT_WRITE_BIT])) // RL16
    && (sp_operate_r == $past(cmd_r.op[drbk_pkg::SETPOINT_OPERATE_BIT])))
    else $error("set-point selectors not written");

  strap_lock_a: assert property (strap_done_r |=> $stable(strap_resistor_r)) // RL10
    else $error("calibration strap changed after capture");
endmodule

// file: drbk_ctrl_model.sv
`timescale 1ns/1ns
// controller side: frames its own command clock, which stands still between commands
module drbk_ctrl_model (
  input wire logic clk,
  input wire logic [7:0] dq,
  input wire logic dq_oe,
  output logic ck,
  output drbk_pkg::drbk_cmd_s cmd
);
  initial
  begin
    ck = 1'b0;
    cmd = '0;
  end

  task automatic send(input logic w, input logic r, input logic c, input logic [7:0] ma, input logic [7:0] op,
                      output logic [7:0] rd, output logic oe);
    logic [7:0] v;
    v = op;
    if (w && ma == drbk_pkg::MA_VENDOR_TEST_REG)
      v = 8'h00;
    @(posedge clk);
    cmd <= '{mrw: w, mrr: r, cal: c, ma: ma, op: v};
    // about half a link period of set-up, then about half a period high
    repeat (16) @(posedge clk);
    ck <= 1'b1;
    repeat (16) @(posedge clk);
    rd = dq;
    oe = dq_oe;
    ck <= 1'b0;
    repeat (8) @(posedge clk);
    // released address and data pins show the inverse so a stale value cannot pass
    cmd <= '{mrw: 1'b0, mrr: 1'b0, cal: 1'b0, ma: ~ma, op: ~v};
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // value is arbitrary
  localparam logic [6:0] REV = 7'h15;
  localparam logic [3:0] DEN = 4'h6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b1;
  logic [7:0] dq_in = 8'h00;
  logic ck;
  drbk_pkg::drbk_cmd_s cmd;
  logic [7:0] dq_out;
  logic [7:0] term;
  logic [5:0] lvl;
  logic dq_oe, range_o, wsel_o, osel_o, use_def, cal_run, cal_rst;
  int bad_count = 0;
  int check_count = 0;
  int ca[2];
  int tm[2];
  logic ws, os;
  int n_run = 0, n_rst = 0, e_run = 0, e_rst = 0;
  logic [31:0] seed = 32'h0000B50E;
  logic [7:0] mas[8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h5E};

  always #2 clk = ~clk;

  drbk_mode_regs #(.REVISION_CODE(REV), .SE_SUPPORTED(1'b1), .DENSITY_CODE(DEN)) i_dut (
    .REF_CLK(clk), .RST_N(rst_n), .CK(ck), .CMD_MRW(cmd.mrw), .CMD_MRR(cmd.mrr), .CMD_CAL(cmd.cal),
    .CMD_MA(cmd.ma), .CMD_OP(cmd.op), .CAL_PIN_TO_RESISTOR(strap), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .CA_REF_LEVEL(lvl), .CA_REF_RANGE(range_o), .TERM_FEATURE(term),
    .SETPOINT_WRITE(wsel_o), .SETPOINT_OPERATE(osel_o), .CAL_USE_DEFAULT(use_def), .CAL_RUN(cal_run),
    .CAL_DEFAULT_RESET(cal_rst));

  drbk_ctrl_model i_ctrl (.clk(clk), .dq(dq_out), .dq_oe(dq_oe), .ck(ck), .cmd(cmd));

  always @(posedge clk)
  begin
    if (cal_run === 1'b1)
      n_run++;
    if (cal_rst === 1'b1)
      n_rst++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] ma);
    case (ma)
      8'h07: return {REV, 1'b1};
      8'h08: return {2'h0, DEN, 2'h0};
      8'h0B: return 8'(tm[ws]);
      8'h0C: return 8'(ca[ws]);
      8'h0D: return {os, ws, 6'h00};
      default: return 8'h00;
    endcase
  endfunction

  task automatic mdl_wr(input logic [7:0] ma, input logic [7:0] op);
    case (ma)
      8'h0A: if (op[0] && strap) e_rst++;
      8'h0B: tm[ws] = int'(op);
      8'h0C: if (op[5:0] <= 6'h32) ca[ws] = int'(op[6:0]);
      8'h0D:
      begin
        ws = op[6];
        os = op[7];
      end
      default: ;
    endcase
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic r, input logic c, input logic [7:0] ma, input logic [7:0] op);
    logic [7:0] e;
    logic [7:0] rd;
    logic oe;
    e = exp_rd(ma);
    dq_in <= 8'(xs());
    i_ctrl.send(w, r, c, ma, op, rd, oe);
    if (w)
      mdl_wr(ma, op);
    if (c && strap)
      e_run++;
    chk(rd, r ? e : 8'h00);
    chk(8'(oe), 8'(r));
    chk(8'(lvl), 8'(ca[os] & 63));
    chk(8'(range_o), 8'((ca[os] >> 6) & 1));
    chk(term, 8'(tm[os]));
    chk({6'h00, osel_o, wsel_o}, {6'h00, os, ws});
    chk(8'(n_run), 8'(e_run));
    chk(8'(n_rst), 8'(e_rst));
  endtask

  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    ca = '{77, 77};
    tm = '{0, 0};
    ws = 1'b0;
    os = 1'b0;
    chk(8'(use_def), 8'(!s));
    chk(8'(lvl), 8'h0D);
    chk(8'(range_o), 8'h01);
    chk(8'(dq_oe), 8'h00);
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial
  begin
    do_reset(1'b1);
    acc(1'b1, 1'b1, 1'b0, 8'h07, 8'hFF);
    acc(1'b1, 1'b1, 1'b0, 8'h08, 8'hFF);
    acc(1'b0, 1'b1, 1'b0, 8'h08, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 8'h0C, 8'hF2);
    acc(1'b1, 1'b1, 1'b0, 8'h0C, 8'h33);
    acc(1'b1, 1'b0, 1'b0, 8'h0D, 8'h40);
    acc(1'b1, 1'b1, 1'b0, 8'h0C, 8'h05);
    acc(1'b1, 1'b1, 1'b0, 8'h0D, 8'hC0);
    acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 8'h0A, 8'h01);
    acc(1'b1, 1'b1, 1'b0, 8'h0A, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      acc(1'b1, 1'b0, 1'b0, mas[xs() % 8], 8'(xs()));
      acc(1'b0, 1'b1, 1'b0, mas[xs() % 8], 8'h00);
    end
    // grounded strap: second reset also proves settings do not survive it
    do_reset(1'b0);
    acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
    acc(1'b1, 1'b1, 1'b0, 8'h0A, 8'h01);
    acc(1'b0, 1'b1, 1'b0, 8'h0C, 8'h00);
    end_of_test();
  end
endmodule
